// ---- bpc_map.svh ----
// constants for the battery protection state controller
// assumes a single 200 MHz core clock and comparator levels from the analog front end
`ifndef BPC_MAP_SVH
`define BPC_MAP_SVH

`define BPC_CLK_HZ                  200.0e6
`define BPC_OVERCHARGE_DELAY_S      1.2
`define BPC_OVERDISCHARGE_DELAY_S   0.150
`define BPC_DSG_OC_DELAY_S          0.009
`define BPC_CHG_OC_DELAY_S          0.009
`define BPC_LOAD_SHORT_DELAY_S      0.000300

`define BPC_TMR_W                   28
`define BPC_TMR_N                   5
`define BPC_TMR_OVCHG               0
`define BPC_TMR_OVDSG               1
`define BPC_TMR_DSG_OC              2
`define BPC_TMR_SHORT               3
`define BPC_TMR_CHG_OC              4

`define BPC_SHUTDOWN_OPT_RST        1'h1

`endif

// ---- bpc_pkg.sv ----
// types shared by the battery protection state controller
// no constants here; figures live in bpc_map.svh
package bpc_pkg;

  typedef enum logic [6:0] {
    ST_NORMAL = 7'h01,
    ST_OVCHG  = 7'h02,
    ST_OVDSG  = 7'h04,
    ST_SHDN   = 7'h08,
    ST_DSG_OC = 7'h10,
    ST_SHORT  = 7'h20,
    ST_CHG_OC = 7'h40
  } bpc_state_t;

  // comparator outputs, one bit each, high when the named condition is true
  typedef struct packed {
    logic cell_above_oc_det;   // cell above overcharge_detect_level
    logic cell_below_oc_rel;   // cell below overcharge_release_level
    logic cell_below_od_det;   // cell below overdischarge_detect_level
    logic cell_above_od_rel;   // cell at or above overdischarge_release_level
    logic sense_above_dsg_oc;  // load_sense_pin above discharge_overcurrent_level
    logic sense_above_short;   // load_sense_pin at or above load_short_level
    logic sense_below_chg_oc;  // load_sense_pin below charge_overcurrent_level
    logic sense_below_chgr;    // load_sense_pin below about -0.7 V
    logic sense_near_supply;   // supply minus load_sense_pin at or below about 1.3 V
  } bpc_cmp_t;

  typedef struct packed {
    logic chg_on;
    logic dsg_on;
    logic pullup_en;
    logic pulldn_en;
    logic shutdown;
  } bpc_sw_t;

endpackage

// ---- bpc_ctrl.sv ----
// protection state machine for a single-cell battery pack
// assumes comparator levels arrive asynchronously; clock and reset from on-chip sources
//
// Functional notes
// - Normal state: charge and discharge switches both on.
// - Cell above overcharge level for full delay: charge off, enter overcharge.
// - Overcharge: sense pull-up and pull-down both disconnected.
// - Overcharge ends when cell below release level and no charger present.
// - Overcharge also ends when load present, no charger present, and cell below detect level.
// - Charger and load both present after overcharge: charge switch stays off.
// - Cell below over-discharge level for full delay: discharge off, enter over-discharge.
// - Over-discharge: sense pull-up connected, pull-down disconnected.
// - Shutdown option: over-discharged with sense near supply enters shutdown.
// - Shutdown ends once charger attached and sense leaves supply by 1.3V.
// - Over-discharge with charger: release once cell reaches detect level.
// - Over-discharge without charger: release only at release level.
// - Discharge over-current for full delay: discharge off, enter that state.
// - Discharge over-current: pull-down connected, pull-up disconnected.
// - Discharge over-current ends when sense falls to its threshold or lower.
// - Sense at short level for full delay: discharge off, enter load short.
// - Load short: pull-down connected, pull-up disconnected.
// - Charge over-current for full delay: charge off, enter that state.
// - Charge over-current ends when sense rises back to its threshold.
// - Charge over-current detection is off during over-discharge.
// - Charge over-current: pull-up and pull-down both disconnected.
`timescale 1ns/1ps
`include "bpc_map.svh"

module bpc_ctrl
  import bpc_pkg::*;
#(
  parameter int unsigned OVERCHARGE_CYC    = $rtoi(`BPC_OVERCHARGE_DELAY_S * `BPC_CLK_HZ),
  parameter int unsigned OVERDISCHARGE_CYC = $rtoi(`BPC_OVERDISCHARGE_DELAY_S * `BPC_CLK_HZ),
  parameter int unsigned DSG_OC_CYC        = $rtoi(`BPC_DSG_OC_DELAY_S * `BPC_CLK_HZ),
  parameter int unsigned CHG_OC_CYC        = $rtoi(`BPC_CHG_OC_DELAY_S * `BPC_CLK_HZ),
  parameter int unsigned LOAD_SHORT_CYC    = $rtoi(`BPC_LOAD_SHORT_DELAY_S * `BPC_CLK_HZ),
  parameter logic        SHUTDOWN_OPT      = `BPC_SHUTDOWN_OPT_RST
) (
  // clock and reset
  input  wire logic       CORE_CLK,
  input  wire logic       RESET_N,
  // analog comparator levels, asynchronous
  input  wire bpc_cmp_t   CMP_RAW,
  // switch and resistor controls
  output bpc_sw_t         SW_CTRL,
  // present protection state
  output bpc_state_t      STATE
);

  localparam int TW = `BPC_TMR_W;
  localparam int TN = `BPC_TMR_N;

  // terminal values, one below the cycle count so a condition held n cycles fires
  localparam logic [TW-1:0] LAST [TN] = '{
    TW'(OVERCHARGE_CYC - 1),
    TW'(OVERDISCHARGE_CYC - 1),
    TW'(DSG_OC_CYC - 1),
    TW'(LOAD_SHORT_CYC - 1),
    TW'(CHG_OC_CYC - 1)
  };

  // saturating count while running, cleared otherwise
  function automatic logic [TW-1:0] tmr_next(input logic          run,
                                             input logic [TW-1:0] cnt,
                                             input logic [TW-1:0] last);
    logic [TW-1:0] nxt;
    nxt = '0;
    if (run) begin
      nxt = (cnt == last) ? cnt : cnt + TW'(1);
    end
    return nxt;
  endfunction

  // switch and resistor settings belonging to each state
  function automatic bpc_sw_t sw_of(input bpc_state_t st);
    bpc_sw_t s;
    s = '{chg_on: 1'b1, dsg_on: 1'b1, pullup_en: 1'b0, pulldn_en: 1'b0, shutdown: 1'b0};
    unique case (st)
      ST_NORMAL: begin
        s.chg_on = 1'b1;
        s.dsg_on = 1'b1;
      end
      ST_OVCHG: begin
        s.chg_on    = 1'b0;
        s.pullup_en = 1'b0;
        s.pulldn_en = 1'b0;
      end
      ST_OVDSG: begin
        s.dsg_on    = 1'b0;
        s.pullup_en = 1'b1;
      end
      ST_SHDN: begin
        // pull-up stays on: it is what holds the sense pin near supply
        s.dsg_on    = 1'b0;
        s.pullup_en = 1'b1;
        s.shutdown  = 1'b1;
      end
      ST_DSG_OC, ST_SHORT: begin
        s.dsg_on    = 1'b0;
        s.pulldn_en = 1'b1;
      end
      ST_CHG_OC: begin
        s.chg_on    = 1'b0;
        s.pullup_en = 1'b0;
        s.pulldn_en = 1'b0;
      end
      default: begin
        s.chg_on = 1'b0;
        s.dsg_on = 1'b0;
      end
    endcase
    return s;
  endfunction

  // two-stage synchroniser; first stage feeds only the second
  bpc_cmp_t cmp_meta_q;
  bpc_cmp_t cmp_q;

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cmp_meta_q <= '0;
      cmp_q      <= '0;
    end else begin
      cmp_meta_q <= CMP_RAW;
      cmp_q      <= cmp_meta_q;
    end
  end

  bpc_state_t    state_q;
  bpc_state_t    state_d;
  logic [TW-1:0] cnt_q [TN];
  logic [TN-1:0] run;
  logic [TN-1:0] fire;
  logic          in_normal;
  logic          charger;
  logic          load;

  assign in_normal = (state_q == ST_NORMAL);
  assign charger   = cmp_q.sense_below_chgr;
  // with both resistors off, a load lifts the sense pin toward the pack
  assign load      = cmp_q.sense_above_dsg_oc;

  // timers run only from the normal state, except over-discharge, which also runs from charge over-current
  always_comb begin
    run = '0;
    run[`BPC_TMR_OVCHG]  = in_normal && cmp_q.cell_above_oc_det;
    run[`BPC_TMR_OVDSG]  = (in_normal || state_q == ST_CHG_OC)
                           && cmp_q.cell_below_od_det;
    run[`BPC_TMR_DSG_OC] = in_normal && cmp_q.sense_above_dsg_oc;
    run[`BPC_TMR_SHORT]  = in_normal && cmp_q.sense_above_short;
    // never runs in over-discharge since it needs the normal state
    run[`BPC_TMR_CHG_OC] = in_normal && cmp_q.sense_below_chg_oc;
  end

  always_comb begin
    for (int i = 0; i < TN; i++) begin
      fire[i] = run[i] && (cnt_q[i] == LAST[i]);
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < TN; i++) begin
        cnt_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < TN; i++) begin
        cnt_q[i] <= tmr_next(run[i], cnt_q[i], LAST[i]);
      end
    end
  end

  // next state; short circuit outranks slower faults when several fire at once
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_NORMAL: begin
        if (fire[`BPC_TMR_SHORT]) begin
          state_d = ST_SHORT;
        end else if (fire[`BPC_TMR_DSG_OC]) begin
          state_d = ST_DSG_OC;
        end else if (fire[`BPC_TMR_OVDSG]) begin
          state_d = ST_OVDSG;
        end else if (fire[`BPC_TMR_OVCHG]) begin
          state_d = ST_OVCHG;
        end else if (fire[`BPC_TMR_CHG_OC]) begin
          state_d = ST_CHG_OC;
        end
      end
      ST_OVCHG: begin
        // both paths need the charger gone, so charger plus load holds here
        if (cmp_q.cell_below_oc_rel && !charger) begin
          state_d = ST_NORMAL;
        end else if (load && !charger && !cmp_q.cell_above_oc_det) begin
          state_d = ST_NORMAL;
        end
      end
      ST_OVDSG: begin
        if (charger && !cmp_q.cell_below_od_det) begin
          state_d = ST_NORMAL;
        end else if (!charger && cmp_q.cell_above_od_rel) begin
          state_d = ST_NORMAL;
        end else if (SHUTDOWN_OPT && cmp_q.sense_near_supply && !charger) begin
          state_d = ST_SHDN;
        end
      end
      ST_SHDN: begin
        if (charger && !cmp_q.sense_near_supply) begin
          state_d = ST_OVDSG;
        end
      end
      ST_DSG_OC, ST_SHORT: begin
        // short also clears once the pin drops back toward ground
        if (!cmp_q.sense_above_dsg_oc) begin
          state_d = ST_NORMAL;
        end
      end
      ST_CHG_OC: begin
        if (fire[`BPC_TMR_OVDSG]) begin
          state_d = ST_OVDSG;
        end else if (!cmp_q.sense_below_chg_oc) begin
          state_d = ST_NORMAL;
        end
      end
      default: begin
        state_d = ST_NORMAL;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_q <= ST_NORMAL;
    end else begin
      state_q <= state_d;
    end
  end

  // outputs register the next state so they stand aligned with state_q
  bpc_sw_t sw_q;

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sw_q <= '{chg_on: 1'b1, dsg_on: 1'b1, pullup_en: 1'b0, pulldn_en: 1'b0, shutdown: 1'b0};
    end else begin
      sw_q <= sw_of(state_d);
    end
  end

  assign SW_CTRL = sw_q;
  assign STATE   = state_q;

  // checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  AST_NORMAL_BOTH_ON: assert property (
    state_q == ST_NORMAL |-> sw_q.chg_on && sw_q.dsg_on && !sw_q.pullup_en && !sw_q.pulldn_en)
    else $error("normal state without both switches on");

  AST_OVCHG_ENTRY: assert property (
    $rose(state_q == ST_OVCHG) |-> $past(state_q == ST_NORMAL)
      && $past(cnt_q[`BPC_TMR_OVCHG]) == LAST[`BPC_TMR_OVCHG] && !sw_q.chg_on)
    else $error("overcharge entered without full delay");

  AST_OVCHG_PULLS: assert property (
    state_q == ST_OVCHG |-> !sw_q.pullup_en && !sw_q.pulldn_en && sw_q.dsg_on)
    else $error("resistor connected in overcharge");

  AST_OVCHG_REL_NOCHGR: assert property (
    state_q == ST_OVCHG && cmp_q.cell_below_oc_rel && !charger |=> state_q == ST_NORMAL
      && sw_q.chg_on)
    else $error("overcharge not released after charger removal");

  AST_OVCHG_REL_LOAD: assert property (
    state_q == ST_OVCHG && load && !charger && !cmp_q.cell_above_oc_det
      |=> state_q == ST_NORMAL && sw_q.chg_on)
    else $error("overcharge not released with load present");

  AST_OVCHG_HOLD_BOTH: assert property (
    state_q == ST_OVCHG && charger |=> state_q == ST_OVCHG && !sw_q.chg_on)
    else $error("charge switch turned on with charger present");

  AST_OVDSG_PULLS: assert property (
    state_q == ST_OVDSG |-> sw_q.pullup_en && !sw_q.pulldn_en && !sw_q.dsg_on)
    else $error("wrong resistors in over-discharge");

  AST_SHDN_ENTRY: assert property (
    state_q == ST_OVDSG && cmp_q.sense_near_supply && !charger && !cmp_q.cell_above_od_rel
      |=> (SHUTDOWN_OPT ? state_q == ST_SHDN && sw_q.shutdown : state_q == ST_OVDSG))
    else $error("shutdown entry wrong");

  AST_SHDN_EXIT: assert property (
    state_q == ST_SHDN && charger && !cmp_q.sense_near_supply |=> state_q == ST_OVDSG
      && !sw_q.shutdown)
    else $error("shutdown not left with charger");

  AST_OVDSG_REL_CHGR: assert property (
    state_q == ST_OVDSG && charger && !cmp_q.cell_below_od_det |=> sw_q.dsg_on)
    else $error("over-discharge not released with charger");

  AST_OVDSG_HOLD_NOCHGR: assert property (
    state_q == ST_OVDSG && !charger && !cmp_q.cell_above_od_rel |=> !sw_q.dsg_on)
    else $error("over-discharge released below release level");

  AST_DOC_ENTRY: assert property (
    $rose(state_q == ST_DSG_OC) |-> $past(cnt_q[`BPC_TMR_DSG_OC]) == LAST[`BPC_TMR_DSG_OC]
      && !sw_q.dsg_on)
    else $error("discharge over-current entered early");

  AST_DOC_PULLS: assert property (
    state_q inside {ST_DSG_OC, ST_SHORT} |-> sw_q.pulldn_en && !sw_q.pullup_en && !sw_q.dsg_on)
    else $error("wrong resistors in discharge fault");

  AST_DOC_RELEASE: assert property (
    state_q == ST_DSG_OC && !cmp_q.sense_above_dsg_oc |=> state_q == ST_NORMAL)
    else $error("discharge over-current not released");

  AST_SHORT_ENTRY: assert property (
    $rose(state_q == ST_SHORT) |-> $past(cnt_q[`BPC_TMR_SHORT]) == LAST[`BPC_TMR_SHORT])
    else $error("load short entered early");

  AST_COC_ENTRY: assert property (
    $rose(state_q == ST_CHG_OC) |-> $past(cnt_q[`BPC_TMR_CHG_OC]) == LAST[`BPC_TMR_CHG_OC]
      && !sw_q.chg_on)
    else $error("charge over-current entered early");

  AST_COC_PULLS: assert property (
    state_q == ST_CHG_OC |-> !sw_q.pullup_en && !sw_q.pulldn_en && !sw_q.chg_on)
    else $error("wrong settings in charge over-current");

  AST_COC_RELEASE: assert property (
    state_q == ST_CHG_OC && !cmp_q.sense_below_chg_oc && !fire[`BPC_TMR_OVDSG]
      |=> state_q == ST_NORMAL)
    else $error("charge over-current not released");

  AST_COC_OFF_IN_OD: assert property (
    state_q == ST_OVDSG ##1 state_q == ST_OVDSG |-> cnt_q[`BPC_TMR_CHG_OC] == '0)
    else $error("charge over-current timer ran in over-discharge");

  AST_TMR_RESTART: assert property (
    !run[`BPC_TMR_DSG_OC] |=> cnt_q[`BPC_TMR_DSG_OC] == '0)
    else $error("timer kept count after condition cleared");

  AST_SYNC_LAT: assert property (
    ##2 1'b1 |-> cmp_q == $past(CMP_RAW, 2))
    else $error("comparator synchroniser latency wrong");

  COV_OVCHG:  cover property (state_q == ST_NORMAL ##1 state_q == ST_OVCHG);
  COV_SHDN:   cover property (state_q == ST_OVDSG ##1 state_q == ST_SHDN);
  COV_SHORT:  cover property (state_q == ST_NORMAL ##1 state_q == ST_SHORT);
  COV_CHG_OC: cover property (state_q == ST_CHG_OC ##1 state_q == ST_NORMAL);

endmodule // bpc_ctrl

// ---- bpc_cell_model.sv ----
// comparator front end for the bench: cell, charger and load as millivolt levels
// assumes the bench sets cell and sense levels; supply equals the cell voltage
`timescale 1ns/1ps

module bpc_cell_model
  import bpc_pkg::*;
#(
  parameter int OC_DET_MV  = 4250,
  parameter int OC_REL_MV  = 4150,
  parameter int OD_DET_MV  = 2500,
  parameter int OD_REL_MV  = 2900,
  parameter int DSG_OC_MV  = 100,
  parameter int SHORT_MV   = 500,
  parameter int CHG_OC_MV  = -100,
  parameter int CHGR_MV    = -700,
  parameter int NEAR_MV    = 1300
) (
  // analog levels in millivolts
  input  wire logic signed [15:0] cell_mv,
  input  wire logic signed [15:0] sense_mv,
  // comparator outputs
  output bpc_cmp_t                cmp_raw
);

  logic signed [16:0] headroom;

  // sign extended so a negative sense pin widens the gap
  assign headroom = cell_mv - sense_mv;

  assign cmp_raw.cell_above_oc_det  = cell_mv > OC_DET_MV;
  assign cmp_raw.cell_below_oc_rel  = cell_mv < OC_REL_MV;
  assign cmp_raw.cell_below_od_det  = cell_mv < OD_DET_MV;
  assign cmp_raw.cell_above_od_rel  = cell_mv >= OD_REL_MV;
  assign cmp_raw.sense_above_dsg_oc = sense_mv > DSG_OC_MV;
  assign cmp_raw.sense_above_short  = sense_mv >= SHORT_MV;
  assign cmp_raw.sense_below_chg_oc = sense_mv < CHG_OC_MV;
  assign cmp_raw.sense_below_chgr   = sense_mv < CHGR_MV;
  assign cmp_raw.sense_near_supply  = headroom <= NEAR_MV;

endmodule // bpc_cell_model

// ---- battery_protection_state_ctrl_tb.sv ----
// self-checking bench for the protection state controller
// assumes shortened delay parameters; levels change on the falling clock edge
`timescale 1ns/1ps

module battery_protection_state_ctrl_tb;
  import bpc_pkg::*;

  localparam int OC_N = 8;
  localparam int OD_N = 7;
  localparam int DO_N = 6;
  localparam int CO_N = 6;
  localparam int SH_N = 3;

  logic               core_clk;
  logic               reset_n;
  logic signed [15:0] cell_mv;
  logic signed [15:0] sense_mv;
  bpc_cmp_t           cmp_raw;
  bpc_sw_t            sw_ctrl;
  bpc_state_t         state;
  int                 n_errors = 0;
  int                 samples_checked = 0;
  int                 cycles = 0;

  bpc_cell_model bpc_cell_model_i (
    .cell_mv  (cell_mv),
    .sense_mv (sense_mv),
    .cmp_raw  (cmp_raw)
  );

  bpc_ctrl #(
    .OVERCHARGE_CYC    (OC_N),
    .OVERDISCHARGE_CYC (OD_N),
    .DSG_OC_CYC        (DO_N),
    .CHG_OC_CYC        (CO_N),
    .LOAD_SHORT_CYC    (SH_N),
    .SHUTDOWN_OPT      (1'h1)
  ) bpc_ctrl_i (
    .CORE_CLK (core_clk),
    .RESET_N  (reset_n),
    .CMP_RAW  (cmp_raw),
    .SW_CTRL  (sw_ctrl),
    .STATE    (state)
  );

  initial begin
    core_clk = 1'h0;
    forever #2.5 core_clk = ~core_clk;
  end

  function automatic bpc_sw_t exp_sw(input bpc_state_t s);
    bpc_sw_t w;
    w.chg_on    = !(s inside {ST_OVCHG, ST_CHG_OC});
    w.dsg_on    = s inside {ST_NORMAL, ST_OVCHG, ST_CHG_OC};
    w.pullup_en = s inside {ST_OVDSG, ST_SHDN};
    w.pulldn_en = s inside {ST_DSG_OC, ST_SHORT};
    w.shutdown  = s == ST_SHDN;
    return w;
  endfunction

  task automatic stop_test;
    if (n_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chk_st(input bpc_state_t exp);
    chk("state", {9'h0, state}, {9'h0, exp});
    chk("switches", {11'h0, sw_ctrl}, {11'h0, exp_sw(exp)});
  endtask

  // new levels, then the old state must last n+1 edges and change on the next
  task automatic step(input int c, input int s, input int n,
                      input bpc_state_t old_st, input bpc_state_t new_st);
    cell_mv  = c[15:0];
    sense_mv = s[15:0];
    repeat (n + 1) @(negedge core_clk);
    chk_st(old_st);
    @(negedge core_clk);
    chk_st(new_st);
  endtask

  task automatic hold(input int c, input int s, input int n, input bpc_state_t st);
    cell_mv  = c[15:0];
    sense_mv = s[15:0];
    repeat (n) @(negedge core_clk);
    chk_st(st);
  endtask

  task automatic t_reset;
    chk_st(ST_NORMAL);
  endtask

  task automatic t_ovchg;
    step(4300, 0, OC_N, ST_NORMAL, ST_OVCHG);
    hold(4100, -800, 12, ST_OVCHG);
    step(4100, 0, 1, ST_OVCHG, ST_NORMAL);
    step(4300, 0, OC_N, ST_NORMAL, ST_OVCHG);
    hold(4200, 0, 8, ST_OVCHG);
    step(4200, 150, 1, ST_OVCHG, ST_NORMAL);
    hold(3700, 0, 10, ST_NORMAL);
  endtask

  task automatic t_ovdsg;
    step(2000, 0, OD_N, ST_NORMAL, ST_OVDSG);
    hold(2000, -200, 12, ST_OVDSG);
    hold(2700, 0, 10, ST_OVDSG);
    step(3000, 0, 1, ST_OVDSG, ST_NORMAL);
    step(2000, 0, OD_N, ST_NORMAL, ST_OVDSG);
    step(2000, 1000, 1, ST_OVDSG, ST_SHDN);
    hold(2000, 0, 10, ST_SHDN);
    step(2000, -800, 1, ST_SHDN, ST_OVDSG);
    step(2700, -800, 1, ST_OVDSG, ST_NORMAL);
    hold(3700, 0, 10, ST_NORMAL);
  endtask

  task automatic t_dsg_oc;
    // a one-cycle gap just short of the delay must restart the count
    hold(3700, 200, DO_N - 1, ST_NORMAL);
    hold(3700, 0, 1, ST_NORMAL);
    step(3700, 200, DO_N, ST_NORMAL, ST_DSG_OC);
    hold(3700, 150, 8, ST_DSG_OC);
    step(3700, 100, 1, ST_DSG_OC, ST_NORMAL);
  endtask

  task automatic t_short;
    step(3700, 600, SH_N, ST_NORMAL, ST_SHORT);
    step(3700, 0, 1, ST_SHORT, ST_NORMAL);
  endtask

  task automatic t_chg_oc;
    step(3700, -200, CO_N, ST_NORMAL, ST_CHG_OC);
    step(3700, -100, 1, ST_CHG_OC, ST_NORMAL);
  endtask

  // whole run is just under two hundred cycles; the 3000-cycle ceiling leaves ample margin
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      stop_test();
    end
  end

  initial begin
    reset_n  = 1'h0;
    cell_mv  = 16'sh0e74;
    sense_mv = 16'sh0000;
    repeat (16) @(negedge core_clk);
    reset_n = 1'h1;
    @(negedge core_clk);
    t_reset();
    t_ovchg();
    t_ovdsg();
    t_dsg_oc();
    t_short();
    t_chg_oc();
    stop_test();
  end

endmodule // battery_protection_state_ctrl_tb
